// *** src/tec_pkg.sv ***
// Constants for the 8-bit timer/event counter block.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses.
package tec_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_PRELOAD = 4'h4;
    localparam logic [3:0] OFF_COUNT = 4'h8;
    localparam logic [3:0] OFF_MISC = 4'hC;
    localparam logic [7:0] CONTROL_RST = 8'h08;
    localparam logic [7:0] COUNT_FULL = 8'hFF;
    localparam int unsigned MODE_HI_BIT = 7;
    localparam int unsigned MODE_LO_BIT = 6;
    localparam int unsigned CLKSEL_BIT = 5;
    localparam int unsigned RUN_BIT = 4;
    localparam int unsigned EDGE_BIT = 3;
    localparam int unsigned PSC_MSB = 2;
    localparam int unsigned MISC_REMAP_BIT = 0;
    localparam int unsigned MISC_IRQEN_BIT = 1;
    localparam int unsigned MISC_PWMEN_BIT = 2;
    localparam logic [2:0] MISC_RST = 3'h0;
    localparam int unsigned PSC_W = 7;
    typedef enum logic [1:0] {
        TEC_MODE_NONE = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_CAPTURE = 2'b11
    } tec_mode_e;
endpackage

// *** src/tec_edge_sync.sv ***
// Two-flop synchroniser with rise and fall pulse detection.
// Assumes the pin is asynchronous to ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
module tec_edge_sync (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_o = sync_ff;
    assign rise_o = sync_ff & ~prev_ff;
    assign fall_o = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// *** src/tec_timer.sv ***
// 8-bit timer/event counter with Wishbone register access.
// Assumes synchronous bus, pins arrive asynchronously and are synchronised.
`timescale 1ns/100ps
`default_nettype none
module tec_timer #(
    parameter int unsigned PSC_W = tec_pkg::PSC_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [tec_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic counter0_input_pin_i,
    input wire logic counter0_input_pin_alt_i,
    input wire logic low_speed_crystal_i,
    output logic overflow_o,
    output logic irq_o,
    output logic wake_o,
    output logic pin_remap_select_o
);
    logic [7:0] control_ff;
    logic [7:0] preload_ff;
    logic [7:0] counter0_value_ff;
    logic [2:0] misc_control_reg_ff;
    logic [PSC_W-1:0] psc_ff;
    logic lxt_meta_ff;
    logic lxt_sync_ff;
    logic lxt_prev_ff;
    logic capture_active_ff;
    logic ovf_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic pin_sel;
    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic base_tick;
    logic [PSC_W-1:0] psc_mask;
    logic psc_tick;
    logic tick;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic wr_pre;
    logic wr_misc;
    logic running;
    logic cap_start;
    logic cap_stop;
    logic ovf_now;
    tec_pkg::tec_mode_e mode;

    assign mode = tec_pkg::tec_mode_e'(control_ff[tec_pkg::MODE_HI_BIT:
        tec_pkg::MODE_LO_BIT]);
    assign running = control_ff[tec_pkg::RUN_BIT];

    // Bus decode; one-cycle ack for every access
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff & wb_sel_i[0];
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
    assign wr_ctrl = wr & (wb_adr_i == tec_pkg::OFF_CONTROL);
    assign wr_pre = wr & (wb_adr_i == tec_pkg::OFF_PRELOAD);
    assign wr_misc = wr & (wb_adr_i == tec_pkg::OFF_MISC);

    // Pin remap selects source before synchronisation
    assign pin_sel = misc_control_reg_ff[tec_pkg::MISC_REMAP_BIT] ?
        counter0_input_pin_alt_i : counter0_input_pin_i;

    tec_edge_sync u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i(pin_sel),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // Crystal clock sampled as a level; its falling edge is a base tick
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lxt_meta_ff <= 1'b0;
            lxt_sync_ff <= 1'b0;
            lxt_prev_ff <= 1'b0;
        end
        else
        begin
            lxt_meta_ff <= low_speed_crystal_i;
            lxt_sync_ff <= lxt_meta_ff;
            lxt_prev_ff <= lxt_sync_ff;
        end
    end

    // Base clock select, PWM forces system clock
    assign base_tick = (control_ff[tec_pkg::CLKSEL_BIT] &
        ~misc_control_reg_ff[tec_pkg::MISC_PWMEN_BIT]) ?
        (lxt_prev_ff & ~lxt_sync_ff) : 1'b1;

    // Free-running prescaler; tick on the falling edge of the divided bit
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            psc_ff <= '0;
        else if (base_tick)
            psc_ff <= psc_ff + 1'b1;
    end

    // Low ratio bits all ones marks one tick per divided period
    assign psc_mask = ~({PSC_W{1'b1}} << control_ff[tec_pkg::PSC_MSB:0]);
    assign psc_tick = base_tick & (&(psc_ff | ~psc_mask));

    // Capture start and stop edges by edge select
    assign cap_start = control_ff[tec_pkg::EDGE_BIT] ? pin_rise : pin_fall;
    assign cap_stop = control_ff[tec_pkg::EDGE_BIT] ? pin_fall : pin_rise;

    always_comb
    begin
        tick = 1'b0;
        if (running)
        begin
            unique case (mode)
                tec_pkg::TEC_MODE_NONE: tick = 1'b0;
                tec_pkg::TEC_MODE_EVENT: tick = control_ff[tec_pkg::EDGE_BIT]
                    ? pin_fall : pin_rise;
                tec_pkg::TEC_MODE_TIMER: tick = psc_tick;
                tec_pkg::TEC_MODE_CAPTURE: tick = psc_tick &
                    capture_active_ff & ~cap_stop;
            endcase
        end
    end

    assign ovf_now = tick & (counter0_value_ff == tec_pkg::COUNT_FULL);

    // Capture window tracking
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            capture_active_ff <= 1'b0;
        else if (!running || mode != tec_pkg::TEC_MODE_CAPTURE)
            capture_active_ff <= 1'b0;
        else if (!capture_active_ff && cap_start)
            capture_active_ff <= 1'b1;
        else if (capture_active_ff && cap_stop)
            capture_active_ff <= 1'b0;
    end

    // Control register; capture end clears run enable over a write
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            control_ff <= tec_pkg::CONTROL_RST;
        else if (running && mode == tec_pkg::TEC_MODE_CAPTURE &&
                 capture_active_ff && cap_stop)
            control_ff[tec_pkg::RUN_BIT] <= 1'b0;
        else if (wr_ctrl)
            control_ff <= wb_dat_i[7:0];
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            misc_control_reg_ff <= tec_pkg::MISC_RST;
        else if (wr_misc)
            misc_control_reg_ff <= wb_dat_i[2:0];
    end

    // Preload has no reset
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_pre)
            preload_ff <= wb_dat_i[7:0];
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            counter0_value_ff <= 8'h00;
        else if (wr_pre && !running)
            counter0_value_ff <= wb_dat_i[7:0];
        else if (ovf_now)
            counter0_value_ff <= preload_ff;
        else if (tick)
            counter0_value_ff <= counter0_value_ff + 8'h01;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ovf_ff <= 1'b0;
        else
            ovf_ff <= ovf_now;
    end

    assign overflow_o = ovf_ff;
    assign irq_o = ovf_ff & misc_control_reg_ff[tec_pkg::MISC_IRQEN_BIT];
    assign wake_o = irq_o;
    assign pin_remap_select_o = misc_control_reg_ff[tec_pkg::MISC_REMAP_BIT];

    // Read data and ack
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
            if (rd)
            begin
                unique case (wb_adr_i)
                    tec_pkg::OFF_CONTROL: rdata_ff <= {24'h0, control_ff};
                    tec_pkg::OFF_PRELOAD: rdata_ff <= {24'h0, preload_ff};
                    tec_pkg::OFF_COUNT:
                        rdata_ff <= {24'h0, counter0_value_ff};
                    tec_pkg::OFF_MISC:
                        rdata_ff <= {29'h0, misc_control_reg_ff};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    property p_ovf_reload;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ovf_now && !(wr_pre && !running)) |=>
            (counter0_value_ff == $past(preload_ff)) && overflow_o;
    endproperty
    a_ovf_reload: assert property (p_ovf_reload)
        else $error("overflow did not reload");

    property p_ovf_pulse;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (overflow_o && !ovf_now) |=> !overflow_o;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow pulse longer than one cycle");

    property p_direct_load;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_pre && !running) |=> counter0_value_ff == $past(wb_dat_i[7:0]);
    endproperty
    a_direct_load: assert property (p_direct_load)
        else $error("disabled preload write missed counter");

    property p_halt;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (!running && !wr_pre) |=> $stable(counter0_value_ff);
    endproperty
    a_halt: assert property (p_halt)
        else $error("counter moved while halted");

    property p_irq_gate;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        irq_o |-> overflow_o && misc_control_reg_ff[tec_pkg::MISC_IRQEN_BIT];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable");

    property p_cap_clear;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (capture_active_ff && cap_stop && running &&
         mode == tec_pkg::TEC_MODE_CAPTURE) |=> !running;
    endproperty
    a_cap_clear: assert property (p_cap_clear)
        else $error("capture end did not clear run");

    property p_cap_wait;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (mode == tec_pkg::TEC_MODE_CAPTURE && !capture_active_ff) |-> !tick;
    endproperty
    a_cap_wait: assert property (p_cap_wait)
        else $error("capture counted before start edge");

    property p_event_edge;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (mode == tec_pkg::TEC_MODE_EVENT && tick) |->
            (control_ff[tec_pkg::EDGE_BIT] ? pin_fall : pin_rise);
    endproperty
    a_event_edge: assert property (p_event_edge)
        else $error("event counted on wrong edge");

    property p_ack_drop;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack held two cycles");

    property p_event_step;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (mode == tec_pkg::TEC_MODE_EVENT && running &&
         counter0_value_ff != tec_pkg::COUNT_FULL &&
         (control_ff[tec_pkg::EDGE_BIT] ? pin_fall : pin_rise)) |=>
            counter0_value_ff == $past(counter0_value_ff) + 8'h01;
    endproperty
    a_event_step: assert property (p_event_step)
        else $error("event edge did not advance counter");

    property p_running_preload;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_pre && running && !tick) |=> $stable(counter0_value_ff);
    endproperty
    a_running_preload: assert property (p_running_preload)
        else $error("running preload write reached counter");

    property p_run_sticky;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (!running && !wr_ctrl) |=> !running;
    endproperty
    a_run_sticky: assert property (p_run_sticky)
        else $error("run enable set without software");

    property p_pwm_base;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        misc_control_reg_ff[tec_pkg::MISC_PWMEN_BIT] |-> base_tick;
    endproperty
    a_pwm_base: assert property (p_pwm_base)
        else $error("pwm enable did not force system clock");
endmodule
`default_nettype wire

// *** verif/tec_pin_source.sv ***
// Pin source model driving the default and alternate counter pins.
// Assumes the bench calls toggle just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module tec_pin_source (
    input wire logic clk_i,
    output logic pin_o,
    output logic alt_o
);
    initial
    begin
        pin_o = 1'b0;
        alt_o = 1'b0;
    end
    // Levels held 6 clocks so the synchroniser sees every edge
    task automatic toggle(input int n, input logic alt);
        repeat (n)
        begin
            repeat (6) @(posedge clk_i);
            if (alt)
                alt_o <= ~alt_o;
            else
                pin_o <= ~pin_o;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the 8-bit timer/event counter.
// Assumes a 50 MHz clock and the pin source model on the counter pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    logic pin;
    logic alt;
    logic lsc = 1'b0;
    logic [2:0] lsc_cnt = 3'h0;
    logic ovf;
    logic irq;
    logic wake;
    logic remap;
    logic [7:0] q;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #10 ref_clk = ~ref_clk;
    // Slow crystal with a period of ten system clocks
    always @(posedge ref_clk)
    begin
        lsc_cnt <= (lsc_cnt == 3'h4) ? 3'h0 : lsc_cnt + 3'h1;
        if (lsc_cnt == 3'h4)
            lsc <= ~lsc;
    end
    tec_timer tec_timer_i (.ref_clk_i(ref_clk), .resetn_i(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .counter0_input_pin_i(pin), .counter0_input_pin_alt_i(alt),
        .low_speed_crystal_i(lsc), .overflow_o(ovf), .irq_o(irq),
        .wake_o(wake), .pin_remap_select_o(remap));
    tec_pin_source tec_pin_source_i (.clk_i(ref_clk), .pin_o(pin),
        .alt_o(alt));
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int t;
        cyc <= 1'b1;
        sel <= 4'hF;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        t = 0;
        do
        begin
            @(posedge ref_clk);
            t++;
        end
        while (ack !== 1'b1 && t < 50);
        if (t >= 50)
            n_mismatch++;
        q = rdat[7:0];
        cyc <= 1'b0;
        sel <= 4'h0;
        @(posedge ref_clk);
    endtask
    task automatic wait_ovf(output int g);
        g = 0;
        do
        begin
            @(posedge ref_clk);
            g++;
        end
        while (ovf !== 1'b1 && g < 2000);
        if (ovf !== 1'b1)
            n_mismatch++;
    endtask
    task automatic t_reset();
        wb(1'b0, tec_pkg::OFF_CONTROL, 8'h00);
        `CHK("control", tec_pkg::CONTROL_RST, q)
        wb(1'b0, tec_pkg::OFF_MISC, 8'h00);
        `CHK("misc", 8'h00, q)
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("count", 8'h00, q)
        wb(1'b0, 4'h2, 8'h00);
        `CHK("unmapped", 8'h00, q)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'hA5);
        wb(1'b0, tec_pkg::OFF_CONTROL, 8'h00);
        `CHK("control rw", 8'hA5, q)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h00);
    endtask
    task automatic t_reload();
        int g;
        wb(1'b1, tec_pkg::OFF_PRELOAD, 8'hFD);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("count load", 8'hFD, q)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h97);
        wb(1'b1, tec_pkg::OFF_PRELOAD, 8'h40);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("count live", 1'b1, q == 8'hFD || q == 8'hFE)
        wait_ovf(g);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("count reload", 8'h40, q)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h00);
    endtask
    task automatic t_timer();
        int g;
        wb(1'b1, tec_pkg::OFF_MISC, 8'h02);
        for (int p = 0; p < 8; p++)
        begin
            wb(1'b1, tec_pkg::OFF_CONTROL, 8'h00);
            wb(1'b1, tec_pkg::OFF_PRELOAD, 8'hFF);
            wb(1'b1, tec_pkg::OFF_CONTROL, 8'h90 | 8'(p));
            wait_ovf(g);
            `CHK("irq", 1'b1, irq & wake)
            wait_ovf(g);
            `CHK("tick gap", 1 << p, g)
        end
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'hB0);
        wait_ovf(g);
        wait_ovf(g);
        `CHK("crystal gap", 10, g)
        wb(1'b1, tec_pkg::OFF_MISC, 8'h04);
        wait_ovf(g);
        `CHK("irq off", 1'b0, irq | wake)
        wait_ovf(g);
        `CHK("pwm gap", 1, g)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h00);
        wb(1'b1, tec_pkg::OFF_MISC, 8'h00);
    endtask
    task automatic cnt_run(input logic [7:0] c, input int n, input logic a);
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h00);
        wb(1'b1, tec_pkg::OFF_PRELOAD, 8'h00);
        wb(1'b1, tec_pkg::OFF_CONTROL, c);
        tec_pin_source_i.toggle(n, a);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
    endtask
    task automatic t_event();
        cnt_run(8'h57, 5, 1'b0);
        `CHK("rising count", 8'h03, q)
        cnt_run(8'h5F, 3, 1'b0);
        `CHK("falling count", 8'h02, q)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h4F);
        tec_pin_source_i.toggle(2, 1'b0);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("halted count", 8'h02, q)
        wb(1'b1, tec_pkg::OFF_CONTROL, 8'h1F);
        tec_pin_source_i.toggle(2, 1'b0);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("no mode count", 8'h02, q)
        wb(1'b1, tec_pkg::OFF_MISC, 8'h01);
        `CHK("remap", 1'b1, remap)
        cnt_run(8'h50, 2, 1'b0);
        tec_pin_source_i.toggle(4, 1'b1);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("alt count", 8'h02, q)
        wb(1'b1, tec_pkg::OFF_MISC, 8'h00);
    endtask
    task automatic t_capture();
        logic [7:0] w;
        cnt_run(8'hD8, 0, 1'b0);
        `CHK("capture idle", 8'h00, q)
        tec_pin_source_i.toggle(2, 1'b0);
        wb(1'b0, tec_pkg::OFF_CONTROL, 8'h00);
        `CHK("run cleared", 8'hC8, q)
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        w = q;
        `CHK("width", 8'h05, q)
        tec_pin_source_i.toggle(2, 1'b0);
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("width kept", w, q)
        cnt_run(8'hD0, 1, 1'b0);
        `CHK("capture held", 8'h00, q)
        tec_pin_source_i.toggle(2, 1'b0);
        wb(1'b0, tec_pkg::OFF_CONTROL, 8'h00);
        `CHK("run cleared low", 8'hC0, q)
        wb(1'b0, tec_pkg::OFF_COUNT, 8'h00);
        `CHK("width low", 8'h05, q)
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_reload();
        t_timer();
        t_event();
        t_capture();
        conclude();
    end
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
